//--- logic/drive_prot_pkg.sv
// package of constants and carrier types for the drive protection supervisor
package drive_prot_pkg;
    // control clock and sample tick
    localparam int  CLK_HZ          = 200_000_000;
    localparam int  TICK_US         = 1000;
    localparam int  TICK_CYCLES     = CLK_HZ / 1_000_000 * TICK_US;
    localparam int  TICKS_PER_SEC   = 1000;
    localparam int  TICKS_PER_TENTH = 100;
    // percent scaling
    localparam int  PCT_FULL        = 100;
    // default settings and limits
    localparam logic [7:0]  ACCEL_STALL_DEF    = 8'h96;   // 150 %
    localparam logic [7:0]  STEADY_STALL_DEF   = 8'h00;
    localparam logic [1:0]  OT_MODE_DEF        = 2'h0;
    localparam logic [7:0]  OT_LEVEL_DEF       = 8'h00;
    localparam logic [7:0]  OT_TIME_DEF        = 8'h0a;   // 1.0 s
    localparam logic [7:0]  OT_TIME_MAX        = 8'hc8;   // 20.0 s
    localparam logic [7:0]  STALL_DECEL_DEF    = 8'h32;   // 5.0 s
    localparam logic [7:0]  FAULT_RESTART_DEF  = 8'h0a;   // 1.0 s
    localparam logic [7:0]  TRACK_RISE_DEF     = 8'h05;
    localparam logic [11:0] RATED_VOLTS_230    = 12'h0dc;  // 220
    localparam logic [11:0] RATED_VOLTS_400    = 12'h17c;  // 380
    localparam logic [5:0]  POLE_MIN           = 6'h02;
    localparam logic [5:0]  POLE_MAX           = 6'h3c;
    localparam logic [5:0]  POLE_DEF           = 6'h04;
    localparam logic [13:0] RPM_MAX            = 14'h270f; // 9999
    localparam logic [13:0] RPM_DEF            = 14'h05a0; // 1440 at 50 Hz
    localparam logic [6:0]  NOLOAD_DEF         = 7'h28;   // 40 %
    localparam logic [9:0]  SLIP_GAIN_MAX      = 10'h3e8; // 1000
    localparam logic [13:0] OP_LIMIT_DEF       = 14'h03e8; // 10.00
    localparam logic [7:0]  OP_DELAY_DEF       = 8'h05;
    localparam logic [7:0]  OP_DELAY_MAX       = 8'hfa;   // 250 s
    localparam logic [13:0] OP_RESUME_DEF      = 14'h0064; // 1.00
    // over-torque mode bits
    localparam int  OT_MODE_STOP_BIT = 0;
    localparam int  OT_MODE_RUN_BIT  = 1;

    typedef enum logic [1:0] {
        ST_RUN   = 2'b00,
        ST_OTRIP = 2'b01,
        ST_PTRIP = 2'b10,
        ST_ITRIP = 2'b11
    } prot_state_t;

    // keypad settings travel together
    typedef struct packed {
        logic [7:0]  accel_stall_level;
        logic [7:0]  steady_stall_level;
        logic [1:0]  overtorque_mode;
        logic [7:0]  overtorque_level;
        logic [7:0]  overtorque_time;
        logic [7:0]  steady_stall_decel_time;
        logic        fault_restart_en;
        logic [7:0]  fault_restart_time;
        logic [7:0]  track_voltage_rise_time;
        logic [11:0] motor_rated_volts;
        logic [11:0] motor_rated_amps;
        logic [5:0]  motor_pole_count;
        logic [13:0] motor_rated_rpm;
        logic [6:0]  motor_noload_amps;
        logic [9:0]  slip_comp_gain;
        logic [13:0] overpressure_limit;
        logic [7:0]  overpressure_delay;
        logic [13:0] overpressure_resume_level;
        logic [7:0]  overpressure_resume_time;
    } prot_cfg_t;

    // measured drive state
    typedef struct packed {
        logic        running;
        logic        accelerating;
        logic        at_speed;
        logic        track_start;
        logic [11:0] out_amps;     // 0.1 A
        logic [13:0] pressure;     // 0.01 kg
    } drive_meas_t;
endpackage : drive_prot_pkg

//--- logic/drive_protection_supervisor.sv
// protection supervisor: stall, over-torque, over-pressure and restart
`timescale 1ns/1ps

// How it works
// - accel stall freezes ramp; zero disables
// - steady stall lowers frequency; zero disables
// - stall lowering rate set by decel time
// - percent thresholds scale to rated current
// - mode picks detect window and stop action
// - over-torque level zero disables detection
// - half detect time raises torque alarm
// - full detect time trips and stops output
// - fault restart after restart time elapses
// - track start voltage rises over rise time
// - trip when current exceeds rated amps
// - rated volts default 220 or 380
// - pole count 02 to 60, default 04
// - rated rpm shown unchanged, max 9999
// - no-load current feeds slip compensation
// - slip gain 0..1000 raises output frequency
// - over-pressure held past delay stops system
// - over-pressure delay 0..250 s
// - resume below level after resume time
// - resume time 0..250 s
module drive_protection_supervisor
    import drive_prot_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        class_400v,
    input  wire prot_cfg_t   cfg,
    input  wire drive_meas_t meas,
    output logic             ramp_hold,
    output logic             freq_lower,
    output logic [7:0]       lower_rate_time,
    output logic             overtorque_alarm,
    output logic             fault,
    output logic             output_enable,
    output logic             overpressure_stop,
    output logic [7:0]       track_volt_step,
    output logic [13:0]      rpm_monitor,
    output logic [11:0]      rated_volts_eff,
    output logic [5:0]       pole_count_eff,
    output logic [15:0]      slip_comp_out
);
    // percent of rated current to 0.1 A units
    function automatic logic [19:0] pct_amps(input logic [7:0] pct,
                                             input logic [11:0] rated);
        pct_amps = 20'((32'(pct) * 32'(rated)) / PCT_FULL);
    endfunction : pct_amps

    // tick and second-based counters need 18 bits: 200000 and 250000 ticks
    logic [17:0]      tick_cnt_reg;
    logic             tick;
    logic [15:0]      ot_cnt_reg;
    logic [17:0]      op_cnt_reg;
    logic [17:0]      rs_cnt_reg;
    logic [15:0]      fr_cnt_reg;
    prot_state_t      state_reg;
    prot_state_t      state_next;
    logic             alarm_reg;
    logic             ramp_hold_reg;
    logic             freq_lower_reg;
    logic [15:0]      slip_reg;
    logic             cfg_volts_zero;
    logic             cfg_poles_bad;

    // sample tick divider
    assign tick = (tick_cnt_reg == 18'(TICK_CYCLES - 1));
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) tick_cnt_reg <= 18'h00000;
        else tick_cnt_reg <= tick ? 18'h00000 : tick_cnt_reg + 18'h00001;
    end

    // threshold comparisons in 0.1 A
    wire [19:0] amps     = {8'h00, meas.out_amps};
    wire [19:0] acc_thr  = pct_amps(cfg.accel_stall_level,
                                    cfg.motor_rated_amps);
    wire [19:0] std_thr  = pct_amps(cfg.steady_stall_level,
                                    cfg.motor_rated_amps);
    wire [19:0] ot_thr   = pct_amps(cfg.overtorque_level,
                                    cfg.motor_rated_amps);
    wire        acc_stall = meas.running && meas.accelerating &&
                            cfg.accel_stall_level != 8'h00 &&
                            amps > acc_thr;
    wire        std_stall = meas.running && meas.at_speed &&
                            cfg.steady_stall_level != 8'h00 &&
                            amps > std_thr;
    wire        ot_window = cfg.overtorque_mode[OT_MODE_RUN_BIT] ?
                            meas.running :
                            (meas.running && meas.at_speed);
    wire        ot_cond   = ot_window && cfg.overtorque_level != 8'h00 &&
                            amps > ot_thr;
    wire        ot_stops  = cfg.overtorque_mode[OT_MODE_STOP_BIT];
    wire        oc_cond   = meas.running &&
                            meas.out_amps > cfg.motor_rated_amps;
    wire        op_cond   = meas.pressure > cfg.overpressure_limit;
    wire        rs_cond   = meas.pressure < cfg.overpressure_resume_level;

    // time settings in ticks, clamped except fault restart time
    wire [7:0]  ot_time_c = (cfg.overtorque_time > OT_TIME_MAX) ?
                            OT_TIME_MAX : cfg.overtorque_time;
    wire [15:0] ot_full   = 16'(32'(ot_time_c) * TICKS_PER_TENTH);
    wire [15:0] ot_half   = {1'b0, ot_full[15:1]};
    wire [7:0]  op_dly_c  = (cfg.overpressure_delay > OP_DELAY_MAX) ?
                            OP_DELAY_MAX : cfg.overpressure_delay;
    wire [7:0]  rs_tim_c  = (cfg.overpressure_resume_time > OP_DELAY_MAX) ?
                            OP_DELAY_MAX :
                            cfg.overpressure_resume_time;
    wire [17:0] op_full   = 18'(32'(op_dly_c) * TICKS_PER_SEC);
    wire [17:0] rs_full   = 18'(32'(rs_tim_c) * TICKS_PER_SEC);
    wire [15:0] fr_full   = 16'(32'(cfg.fault_restart_time) *
                                TICKS_PER_TENTH);

    // elapsed-time counters, cleared when their cause drops
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ot_cnt_reg <= 16'h0000;
            op_cnt_reg <= 18'h00000;
            rs_cnt_reg <= 18'h00000;
            fr_cnt_reg <= 16'h0000;
        end else if (tick) begin
            ot_cnt_reg <= (ot_cond && state_reg == ST_RUN) ?
                          ot_cnt_reg + {15'h0, ot_cnt_reg != 16'hffff} :
                          16'h0000;
            op_cnt_reg <= (op_cond && state_reg == ST_RUN) ?
                          op_cnt_reg + {17'h0, op_cnt_reg != 18'h3ffff} :
                          18'h00000;
            rs_cnt_reg <= (rs_cond && state_reg == ST_PTRIP) ?
                          rs_cnt_reg + {17'h0, rs_cnt_reg != 18'h3ffff} :
                          18'h00000;
            fr_cnt_reg <= (state_reg == ST_OTRIP ||
                           state_reg == ST_ITRIP) ?
                          fr_cnt_reg + {15'h0, fr_cnt_reg != 16'hffff} :
                          16'h0000;
        end
    end

    wire ot_half_hit = ot_cond && ot_cnt_reg > ot_half;
    wire ot_full_hit = ot_cond && ot_cnt_reg > ot_full;
    wire op_hit      = op_cond && op_cnt_reg > op_full;
    wire rs_hit      = rs_cond && rs_cnt_reg > rs_full;
    wire fr_hit      = cfg.fault_restart_en &&
                       fr_cnt_reg > fr_full;

    // protection state machine
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_RUN: begin
                if (tick && oc_cond) state_next = ST_ITRIP;
                else if (tick && ot_full_hit && ot_stops)
                    state_next = ST_OTRIP;
                else if (tick && op_hit) state_next = ST_PTRIP;
            end
            ST_OTRIP, ST_ITRIP: begin
                if (tick && fr_hit) state_next = ST_RUN;
            end
            ST_PTRIP: begin
                if (tick && rs_hit) state_next = ST_RUN;
            end
            default: state_next = ST_RUN;
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) state_reg <= ST_RUN;
        else state_reg <= state_next;
    end

    // stall flags and alarm sampled on the tick
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ramp_hold_reg  <= 1'b0;
            freq_lower_reg <= 1'b0;
            alarm_reg      <= 1'b0;
        end else if (tick) begin
            ramp_hold_reg  <= acc_stall;
            freq_lower_reg <= std_stall;
            alarm_reg      <= ot_half_hit;
        end
    end

    // slip compensation: gain times load current above no-load
    wire [19:0] noload_thr = 20'((32'(cfg.motor_noload_amps) *
                             32'(cfg.motor_rated_amps)) / PCT_FULL);
    wire [19:0] load_amps  = (amps > noload_thr) ? amps - noload_thr :
                             20'h00000;
    wire [9:0]  gain_c     = (cfg.slip_comp_gain > SLIP_GAIN_MAX) ?
                             SLIP_GAIN_MAX : cfg.slip_comp_gain;
    wire [31:0] slip_prod  = (32'(load_amps) * 32'(gain_c)) / 32'd1000;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) slip_reg <= 16'h0000;
        else if (tick)
            slip_reg <= (slip_prod > 32'h0000ffff) ? 16'hffff :
                        slip_prod[15:0];
    end

    // nameplate settings: defaults for zero volts or out-of-range pole count, rpm clamped to max
    assign cfg_volts_zero = (cfg.motor_rated_volts == 12'h000);
    assign cfg_poles_bad  = (cfg.motor_pole_count < POLE_MIN) ||
                            (cfg.motor_pole_count > POLE_MAX);
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rated_volts_eff <= RATED_VOLTS_230;
            pole_count_eff  <= POLE_DEF;
            rpm_monitor     <= RPM_DEF;
            track_volt_step <= TRACK_RISE_DEF;
            lower_rate_time <= STALL_DECEL_DEF;
        end else begin
            rated_volts_eff <= !cfg_volts_zero ? cfg.motor_rated_volts :
                               class_400v ? RATED_VOLTS_400 :
                               RATED_VOLTS_230;
            pole_count_eff  <= cfg_poles_bad ? POLE_DEF :
                               cfg.motor_pole_count;
            rpm_monitor     <= (cfg.motor_rated_rpm > RPM_MAX) ? RPM_MAX :
                               cfg.motor_rated_rpm;
            track_volt_step <= meas.track_start ?
                               cfg.track_voltage_rise_time :
                               8'h00;
            lower_rate_time <= cfg.steady_stall_decel_time;
        end
    end

    // outputs
    assign ramp_hold         = ramp_hold_reg;
    assign freq_lower        = freq_lower_reg;
    assign overtorque_alarm  = alarm_reg;
    assign fault             = (state_reg != ST_RUN);
    assign overpressure_stop = (state_reg == ST_PTRIP);
    assign output_enable     = (state_reg == ST_RUN);
    assign slip_comp_out     = slip_reg;
endmodule : drive_protection_supervisor

//--- tb/drive_prot_assertions.sv
// checker for the protection supervisor ports
`timescale 1ns/1ps
module drive_prot_assertions
    import drive_prot_pkg::*;
(
    input logic        clk_sys,
    input logic        rst,
    input logic        class_400v,
    input prot_cfg_t   cfg,
    input drive_meas_t meas,
    input logic        fault,
    input logic        output_enable,
    input logic        overpressure_stop,
    input logic [7:0]  lower_rate_time,
    input logic [7:0]  track_volt_step,
    input logic [13:0] rpm_monitor,
    input logic [11:0] rated_volts_eff,
    input logic [5:0]  pole_count_eff
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // decoded setting conditions
    wire logic vz      = cfg.motor_rated_volts == 12'h000;
    wire logic pole_ok = cfg.motor_pole_count >= POLE_MIN &&
                         cfg.motor_pole_count <= POLE_MAX;
    property p_fault_oe;
        fault != output_enable;
    endproperty
    a_fault_oe: assert property (p_fault_oe)
        else $error("output enable not the inverse of fault");
    property p_stop_fault;
        overpressure_stop |-> fault;
    endproperty
    a_stop_fault: assert property (p_stop_fault)
        else $error("pressure stop without fault");
    property p_volts_230;
        (vz && !class_400v && !rst) ##1 (vz && !class_400v)
            |-> rated_volts_eff == RATED_VOLTS_230;
    endproperty
    a_volts_230: assert property (p_volts_230)
        else $error("230 class default volts wrong");
    property p_volts_400;
        (vz && class_400v && !rst) ##1 (vz && class_400v)
            |-> rated_volts_eff == RATED_VOLTS_400;
    endproperty
    a_volts_400: assert property (p_volts_400)
        else $error("400 class default volts wrong");
    property p_volts_cfg;
        (!vz && !rst) ##1 (!vz && $stable(cfg.motor_rated_volts))
            |-> rated_volts_eff == cfg.motor_rated_volts;
    endproperty
    a_volts_cfg: assert property (p_volts_cfg)
        else $error("set volts not passed on");
    property p_pole;
        !rst ##1 $stable(cfg.motor_pole_count) |-> pole_count_eff ==
            (pole_ok ? cfg.motor_pole_count : POLE_DEF);
    endproperty
    a_pole: assert property (p_pole)
        else $error("pole count wrong");
    property p_rpm;
        !rst ##1 $stable(cfg.motor_rated_rpm) |-> rpm_monitor ==
            (cfg.motor_rated_rpm > RPM_MAX ? RPM_MAX : cfg.motor_rated_rpm);
    endproperty
    a_rpm: assert property (p_rpm)
        else $error("speed monitor wrong");
    property p_lower;
        !rst ##1 $stable(cfg.steady_stall_decel_time)
            |-> lower_rate_time == cfg.steady_stall_decel_time;
    endproperty
    a_lower: assert property (p_lower)
        else $error("lowering rate wrong");
    property p_track;
        !rst ##1 ($stable(cfg.track_voltage_rise_time) &&
            $stable(meas.track_start)) |-> track_volt_step ==
            (meas.track_start ? cfg.track_voltage_rise_time : 8'h00);
    endproperty
    a_track: assert property (p_track)
        else $error("track rise step wrong");
endmodule : drive_prot_assertions

bind drive_protection_supervisor drive_prot_assertions i_chk (
    .clk_sys(clk_sys), .rst(rst), .class_400v(class_400v), .cfg(cfg),
    .meas(meas), .fault(fault), .output_enable(output_enable),
    .overpressure_stop(overpressure_stop),
    .lower_rate_time(lower_rate_time), .track_volt_step(track_volt_step),
    .rpm_monitor(rpm_monitor), .rated_volts_eff(rated_volts_eff),
    .pole_count_eff(pole_count_eff));

//--- tb/meas_source.sv
// current sensor and pressure transmitter model
`timescale 1ns/1ps
module meas_source
    import drive_prot_pkg::*;
(
    input  logic        clk_sys,
    input  logic [11:0] amps_set,
    input  logic [13:0] press_set,
    input  logic        track_set,
    output drive_meas_t meas
);
    // known state before the first converter result
    initial meas = '0;
    // converter results land just after the rising edge
    always @(posedge clk_sys) begin
        meas <= '{1'b1, 1'b0, 1'b1, track_set, amps_set, press_set};
    end
endmodule : meas_source

//--- tb/tb_top.sv
// testbench for the protection supervisor
`timescale 1ns/1ps
module tb_top;
    import drive_prot_pkg::*;
    typedef struct packed {
        logic [11:0] v; logic [5:0] p; logic [13:0] r; logic c; logic t;
        logic [11:0] ev; logic [5:0] ep; logic [13:0] er;
    } case_t;
    logic clk_sys, rst, class_400v, track_set;
    logic ramp_hold, freq_lower, overtorque_alarm, fault;
    logic output_enable, overpressure_stop;
    logic [7:0] lower_rate_time, track_volt_step;
    logic [13:0] rpm_monitor, press_set;
    logic [11:0] rated_volts_eff, amps_set;
    logic [5:0] pole_count_eff;
    logic [15:0] slip_comp_out;
    prot_cfg_t cfg;
    drive_meas_t meas;
    int n_fail, cmp_count;
    case_t tbl [4] = '{
        '{12'h000, 6'h02, 14'h270f, 1'b0, 1'b0, 12'h0dc, 6'h02, 14'h270f},
        '{12'h000, 6'h3c, 14'h2710, 1'b1, 1'b1, 12'h17c, 6'h3c, 14'h270f},
        '{12'h0e6, 6'h01, 14'h0000, 1'b1, 1'b0, 12'h0e6, 6'h04, 14'h0000},
        '{12'h17c, 6'h3d, 14'h05a0, 1'b0, 1'b1, 12'h17c, 6'h04, 14'h05a0}};
    drive_protection_supervisor i_drive_protection_supervisor (
        .clk_sys(clk_sys), .rst(rst), .class_400v(class_400v), .cfg(cfg),
        .meas(meas), .ramp_hold(ramp_hold), .freq_lower(freq_lower),
        .lower_rate_time(lower_rate_time),
        .overtorque_alarm(overtorque_alarm), .fault(fault),
        .output_enable(output_enable),
        .overpressure_stop(overpressure_stop),
        .track_volt_step(track_volt_step), .rpm_monitor(rpm_monitor),
        .rated_volts_eff(rated_volts_eff), .pole_count_eff(pole_count_eff),
        .slip_comp_out(slip_comp_out));
    meas_source i_meas_source (.clk_sys(clk_sys), .amps_set(amps_set),
        .press_set(press_set), .track_set(track_set), .meas(meas));
    // 200 mhz clock
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : report_and_stop
    // values held while reset is applied
    task automatic chk_defaults;
        chk(16'(output_enable), 16'h0001);
        chk(16'(fault), 16'h0000);
        chk(16'(rated_volts_eff), 16'(RATED_VOLTS_230));
        chk(16'(pole_count_eff), 16'(POLE_DEF));
        chk(16'(rpm_monitor), 16'(RPM_DEF));
        chk(16'(track_volt_step), 16'(TRACK_RISE_DEF));
        chk(16'(lower_rate_time), 16'(STALL_DECEL_DEF));
        chk(slip_comp_out, 16'h0000);
    endtask : chk_defaults
    task automatic run_case(input case_t c);
        @(posedge clk_sys);
        cfg.motor_rated_volts <= c.v;
        cfg.motor_pole_count  <= c.p;
        cfg.motor_rated_rpm   <= c.r;
        class_400v            <= c.c;
        track_set             <= c.t;
        repeat (3) @(posedge clk_sys);
        #1;
        chk(16'(rated_volts_eff), 16'(c.ev));
        chk(16'(pole_count_eff), 16'(c.ep));
        chk(16'(rpm_monitor), 16'(c.er));
        chk(16'(track_volt_step), c.t ? 16'h000c : 16'h0000);
        chk(16'(lower_rate_time), 16'h001e);
    endtask : run_case
    // hang guard
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_fail++;
        report_and_stop();
    end
    // main sequence
    initial begin
        n_fail = 0;
        cmp_count = 0;
        rst = 1'b1;
        class_400v = 1'b0;
        track_set = 1'b0;
        amps_set = 12'h0fa; // 25.0 a, 250 % of rated
        press_set = 14'h07d0; // 20.00, above the limit
        cfg = '0;
        cfg.motor_rated_amps = 12'h064;
        cfg.accel_stall_level = 8'h96;
        cfg.steady_stall_level = 8'h78;
        cfg.overtorque_mode = 2'h3;
        cfg.overtorque_level = 8'h64;
        cfg.overtorque_time = OT_TIME_DEF;
        cfg.steady_stall_decel_time = 8'h1e;
        cfg.track_voltage_rise_time = 8'h0c;
        cfg.overpressure_limit = OP_LIMIT_DEF;
        repeat (8) @(posedge clk_sys);
        #1;
        chk_defaults();
        @(posedge clk_sys);
        rst <= 1'b0;
        foreach (tbl[i]) run_case(tbl[i]);
        // overload far above every level, yet no sample tick has come
        chk(16'({ramp_hold, freq_lower, overtorque_alarm, fault,
            overpressure_stop}), 16'h0000);
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        #1;
        chk_defaults();
        @(posedge clk_sys);
        rst <= 1'b0;
        run_case(tbl[1]);
        report_and_stop();
    end
endmodule : tb_top
